// >>> hdl/uqm_pkg.sv
// Package holding register map, field layout and carrier types of the forwarding bank.
package uqm_pkg;
  localparam logic [7:0] UQM_ADDR_TAG_HI  = 8'h81;
  localparam logic [7:0] UQM_ADDR_SPLIT   = 8'h82;
  localparam logic [7:0] UQM_ADDR_UCAST   = 8'h83;
  localparam logic [7:0] UQM_ADDR_MCAST   = 8'h84;
  localparam int         UQM_TAG4_LSB     = 0;
  localparam int         UQM_SPLIT_LSB    = 6;
  localparam int         UQM_RSV_LSB      = 2;
  localparam int         UQM_EN_BIT       = 5;
  localparam int         UQM_MAP_LSB      = 0;
  localparam logic [1:0] UQM_TAG4_RST     = 2'h2;
  localparam logic [1:0] UQM_SPLIT_RST    = 2'h2;
  localparam logic [1:0] UQM_RSV_VAL      = 2'h1;
  localparam logic [4:0] UQM_MAP_RST      = 5'h00;
  localparam logic       UQM_EN_RST       = 1'h0;
  localparam logic [2:0] UQM_TAG_FOUR     = 3'h4;
  localparam logic [1:0] UQM_PRIO_LOW     = 2'h0;
  localparam logic [1:0] UQM_PRIO_HIGH    = 2'h3;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } uqm_reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] tag;
    logic [1:0] prio_other;
    logic       two_queue;
    logic       ucast;
    logic       mcast;
  } uqm_frame_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] prio;
    logic [1:0] queue;
    logic       apply;
    logic       drop;
    logic [3:0] ports;
  } uqm_decision_t;
endpackage

// >>> hdl/uqm_regs.sv
// Forwarding and two-queue configuration registers with their per-frame decision logic.
`timescale 1ns/1ps

module uqm_regs (
  // Clock and reset.
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_i,
  // Management register port.
  input  wire uqm_pkg::uqm_reg_req_t reg_req_i,
  output logic                       rd_valid_o,
  output logic [7:0]                 rd_data_o,
  // Frame classification.
  input  wire uqm_pkg::uqm_frame_t   frame_i,
  output uqm_pkg::uqm_decision_t     decision_o
);
  import uqm_pkg::*;

  logic [1:0] tag4_reg;
  logic [1:0] split_reg;
  logic       uc_en_reg;
  logic [4:0] uc_map_reg;
  logic       mc_en_reg;
  logic [4:0] mc_map_reg;
  logic [7:0] rd_next;
  logic [1:0] prio_next;
  logic [1:0] queue_next;
  logic       apply_next;
  logic       drop_next;
  logic [3:0] ports_next;
  logic       en_sel;
  logic [4:0] map_sel;

  // Register writes.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tag4_reg  <= UQM_TAG4_RST;
    end else if (reg_req_i.wr && reg_req_i.addr == UQM_ADDR_TAG_HI) begin
      tag4_reg  <= reg_req_i.wdata[UQM_TAG4_LSB +: 2];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      split_reg <= UQM_SPLIT_RST;
    end else if (reg_req_i.wr && reg_req_i.addr == UQM_ADDR_SPLIT) begin
      split_reg <= reg_req_i.wdata[UQM_SPLIT_LSB +: 2];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      uc_en_reg  <= UQM_EN_RST;
      uc_map_reg <= UQM_MAP_RST;
    end else if (reg_req_i.wr && reg_req_i.addr == UQM_ADDR_UCAST) begin
      uc_en_reg  <= reg_req_i.wdata[UQM_EN_BIT];
      uc_map_reg <= reg_req_i.wdata[UQM_MAP_LSB +: 5];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mc_en_reg  <= UQM_EN_RST;
      mc_map_reg <= UQM_MAP_RST;
    end else if (reg_req_i.wr && reg_req_i.addr == UQM_ADDR_MCAST) begin
      mc_en_reg  <= reg_req_i.wdata[UQM_EN_BIT];
      mc_map_reg <= reg_req_i.wdata[UQM_MAP_LSB +: 5];
    end
  end

  // Read multiplexer; unmapped addresses and unused bits read as zero, except the split register's reserved field, which reads 01.
  always_comb begin
    rd_next = 8'h00;
    case (reg_req_i.addr)
      UQM_ADDR_TAG_HI: rd_next[UQM_TAG4_LSB +: 2] = tag4_reg;
      UQM_ADDR_SPLIT: begin
        rd_next[UQM_SPLIT_LSB +: 2] = split_reg;
        rd_next[UQM_RSV_LSB +: 2]   = UQM_RSV_VAL;
      end
      UQM_ADDR_UCAST: begin
        rd_next[UQM_EN_BIT]         = uc_en_reg;
        rd_next[UQM_MAP_LSB +: 5]   = uc_map_reg;
      end
      UQM_ADDR_MCAST: begin
        rd_next[UQM_EN_BIT]         = mc_en_reg;
        rd_next[UQM_MAP_LSB +: 5]   = mc_map_reg;
      end
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o  <= 8'h00;
    end else begin
      rd_valid_o <= reg_req_i.rd;
      rd_data_o  <= reg_req_i.rd ? rd_next : 8'h00;
    end
  end

  // Priority and queue selection.
  always_comb begin
    prio_next = (frame_i.tag == UQM_TAG_FOUR) ? tag4_reg : frame_i.prio_other;
    if (!frame_i.two_queue) begin
      queue_next = prio_next;
    end else begin
      case (prio_next)
        UQM_PRIO_LOW:  queue_next = 2'h0;
        UQM_PRIO_HIGH: queue_next = 2'h1;
        2'h1:          queue_next = {1'b0, split_reg[0]};
        2'h2:          queue_next = {1'b0, split_reg[1]};
        default:       queue_next = 2'h0;
      endcase
    end
  end

  // Unknown destination forwarding.
  always_comb begin
    en_sel  = frame_i.ucast ? uc_en_reg  : mc_en_reg;
    map_sel = frame_i.ucast ? uc_map_reg : mc_map_reg;
    apply_next = (frame_i.ucast || frame_i.mcast) && en_sel;
    ports_next = apply_next ? map_sel[4:1] : 4'h0;
    drop_next  = apply_next && (map_sel[4:1] == 4'h0);
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      decision_o <= '0;
    end else begin
      decision_o.valid <= frame_i.valid;
      decision_o.prio  <= prio_next;
      decision_o.queue <= queue_next;
      decision_o.apply <= frame_i.valid && apply_next;
      decision_o.drop  <= frame_i.valid && drop_next;
      decision_o.ports <= frame_i.valid ? ports_next : 4'h0;
    end
  end

  // Checks.
  sequence s_frame_in;
    frame_i.valid;
  endsequence

  sequence s_tq_prio(logic [1:0] p);
    frame_i.valid && frame_i.two_queue && prio_next == p;
  endsequence

  sequence s_reg_write(logic [7:0] a);
    reg_req_i.wr && reg_req_i.addr == a;
  endsequence

  sequence s_reg_read(logic [7:0] a);
    reg_req_i.rd && reg_req_i.addr == a;
  endsequence

  sequence s_uc_frame;
    frame_i.valid && frame_i.ucast;
  endsequence

  sequence s_mc_frame;
    frame_i.valid && !frame_i.ucast && frame_i.mcast;
  endsequence

  a_tag_four_prio: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_frame_in and frame_i.tag == UQM_TAG_FOUR |=> decision_o.prio == $past(tag4_reg))
    else $error("Tag four priority not taken from its field.");

  a_low_always: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_tq_prio(UQM_PRIO_LOW) |=> decision_o.queue == 2'h0)
    else $error("Priority zero not sent to low queue.");

  a_high_always: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_tq_prio(UQM_PRIO_HIGH) |=> decision_o.queue == 2'h1)
    else $error("Priority three not sent to high queue.");

  a_split_threshold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_tq_prio(2'h2) ##0 split_reg == 2'h2 |=> decision_o.queue == 2'h1)
    else $error("Default split did not send priority two high.");

  a_split_mid: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_tq_prio(2'h1) |=> decision_o.queue == {1'b0, $past(split_reg[0])})
    else $error("Priority one folded wrongly.");

  a_uc_disabled: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_frame_in and frame_i.ucast && !uc_en_reg |=> !decision_o.apply && decision_o.ports == 4'h0)
    else $error("Unicast map applied while disabled.");

  a_mc_disabled: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_frame_in and !frame_i.ucast && frame_i.mcast && !mc_en_reg |=> !decision_o.apply)
    else $error("Multicast map applied while disabled.");

  a_zero_map_drop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_frame_in and frame_i.ucast && uc_en_reg && uc_map_reg[4:1] == 4'h0
    |=> decision_o.drop && decision_o.ports == 4'h0)
    else $error("Zero unicast map did not drop.");

  a_mc_port_decode: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_frame_in and !frame_i.ucast && frame_i.mcast && mc_en_reg
    |=> decision_o.ports == $past(mc_map_reg[4:1])
        && decision_o.drop == ($past(mc_map_reg[4:1]) == 4'h0))
    else $error("Multicast port map decoded wrongly.");

  a_uc_port_mask: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_frame_in and frame_i.ucast && uc_en_reg |=> decision_o.ports == $past(uc_map_reg[4:1]))
    else $error("Unicast port mask decoded wrongly.");

  a_reset_values: assert property (@(posedge clk_sys_i)
    $past(rst_i) |-> tag4_reg == UQM_TAG4_RST && split_reg == UQM_SPLIT_RST
                     && !uc_en_reg && !mc_en_reg && uc_map_reg == 5'h00 && mc_map_reg == 5'h00)
    else $error("Register reset value wrong.");

  a_tag4_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_reg_write(UQM_ADDR_TAG_HI) |=> tag4_reg == $past(reg_req_i.wdata[UQM_TAG4_LSB +: 2]))
    else $error("Tag four field write not taken.");

  a_split_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_reg_write(UQM_ADDR_SPLIT) |=> split_reg == $past(reg_req_i.wdata[UQM_SPLIT_LSB +: 2]))
    else $error("Split field write not taken.");

  a_uc_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_reg_write(UQM_ADDR_UCAST) |=> uc_en_reg == $past(reg_req_i.wdata[UQM_EN_BIT])
        && uc_map_reg == $past(reg_req_i.wdata[UQM_MAP_LSB +: 5]))
    else $error("Unicast register write not taken.");

  a_mc_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_reg_write(UQM_ADDR_MCAST) |=> mc_en_reg == $past(reg_req_i.wdata[UQM_EN_BIT])
        && mc_map_reg == $past(reg_req_i.wdata[UQM_MAP_LSB +: 5]))
    else $error("Multicast register write not taken.");

  a_rd_tag4_value: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_reg_read(UQM_ADDR_TAG_HI)
    |=> rd_valid_o && rd_data_o[UQM_TAG4_LSB +: 2] == $past(tag4_reg))
    else $error("Tag four field read back wrongly.");

  a_rd_split_value: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_reg_read(UQM_ADDR_SPLIT) |=> rd_data_o[UQM_SPLIT_LSB +: 2] == $past(split_reg)
        && rd_data_o[UQM_RSV_LSB +: 2] == UQM_RSV_VAL)
    else $error("Split register read back wrongly.");

  a_rd_uc_value: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_reg_read(UQM_ADDR_UCAST) |=> rd_data_o[UQM_EN_BIT] == $past(uc_en_reg)
        && rd_data_o[UQM_MAP_LSB +: 5] == $past(uc_map_reg))
    else $error("Unicast register read back wrongly.");

  a_rd_mc_value: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_reg_read(UQM_ADDR_MCAST) |=> rd_data_o[UQM_EN_BIT] == $past(mc_en_reg)
        && rd_data_o[UQM_MAP_LSB +: 5] == $past(mc_map_reg))
    else $error("Multicast register read back wrongly.");

  a_rd_idle_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !reg_req_i.rd |=> !rd_valid_o && rd_data_o == 8'h00)
    else $error("Read port not quiet without a read.");

  a_prio_other: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_frame_in and frame_i.tag != UQM_TAG_FOUR
    |=> decision_o.prio == $past(frame_i.prio_other))
    else $error("Other tag priority not passed through.");

  a_one_queue_pass: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_frame_in and !frame_i.two_queue |=> decision_o.queue == decision_o.prio)
    else $error("Queue differs from priority outside two-queue mode.");

  a_two_queue_range: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_frame_in and frame_i.two_queue |=> decision_o.queue[1] == 1'b0)
    else $error("Two-queue result outside low and high.");

  a_split_zero_two: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_tq_prio(2'h2) ##0 split_reg == 2'h0 |=> decision_o.queue == 2'h0)
    else $error("Split 00 did not keep priority two low.");

  a_split_full_one: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_tq_prio(2'h1) ##0 split_reg == 2'h3 |=> decision_o.queue == 2'h1)
    else $error("Split 11 did not send priority one high.");

  a_split_full_two: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_tq_prio(2'h2) ##0 split_reg == 2'h3 |=> decision_o.queue == 2'h1)
    else $error("Split 11 did not send priority two high.");

  a_not_unknown: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_frame_in and !frame_i.ucast && !frame_i.mcast
    |=> !decision_o.apply && !decision_o.drop)
    else $error("Unknown map applied to a known frame.");

  a_idle_quiet: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !frame_i.valid |=> !decision_o.valid && !decision_o.apply
        && !decision_o.drop && decision_o.ports == 4'h0)
    else $error("Decision raised without a frame.");

  a_mc_zero_drop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_mc_frame ##0 mc_en_reg && mc_map_reg[4:1] == 4'h0
    |=> decision_o.drop && decision_o.ports == 4'h0)
    else $error("Zero multicast map did not drop.");

  a_uc_reserved_drop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_uc_frame ##0 uc_en_reg && uc_map_reg == 5'h01 |=> decision_o.drop)
    else $error("Reserved unicast map did not drop.");

  a_drop_no_ports: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    decision_o.drop |-> decision_o.apply && decision_o.ports == 4'h0)
    else $error("Dropped frame still has destinations.");

  a_frame_answer: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_frame_in |=> decision_o.valid)
    else $error("Frame got no decision.");

  a_mc_enabled_apply: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_mc_frame ##0 mc_en_reg |=> decision_o.apply)
    else $error("Enabled multicast map not applied.");

  a_uc_enabled_apply: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_uc_frame ##0 uc_en_reg |=> decision_o.apply)
    else $error("Enabled unicast map not applied.");

  a_reset_outputs: assert property (@(posedge clk_sys_i)
    $past(rst_i) |-> !rd_valid_o && rd_data_o == 8'h00 && decision_o == '0)
    else $error("Outputs not cleared by reset.");

endmodule // uqm_regs

// >>> tb/uqm_testbench.sv
// Self-checking testbench for the forwarding and two-queue register bank.
`timescale 1ns/1ps

module testbench;
  import uqm_pkg::*;

  typedef struct packed {
    logic [1:0] sp;
    logic [1:0] t4;
    logic [7:0] uc;
    logic [7:0] mc;
    logic [2:0] tag;
    logic [1:0] po;
    logic       tq;
    logic       u;
    logic       m;
    logic [1:0] prio;
    logic [1:0] q;
    logic       ap;
    logic       dr;
    logic [3:0] pt;
  } uqm_tb_row_t;

  logic          clk_sys_i;
  logic          rst_i;
  uqm_reg_req_t  req;
  logic          rd_valid;
  logic [7:0]    rd_data;
  uqm_frame_t    frame;
  uqm_decision_t dec;
  int            error_cnt;
  int            total_checks;
  uqm_tb_row_t   rows [14];
  logic [7:0]    addrs [5] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85};
  logic [7:0]    dflt  [5] = '{8'h02, 8'h84, 8'h00, 8'h00, 8'h00};
  logic [7:0]    full  [5] = '{8'h03, 8'hc4, 8'h3f, 8'h3f, 8'h00};

  uqm_regs uut (
    .clk_sys_i  (clk_sys_i),
    .rst_i      (rst_i),
    .reg_req_i  (req),
    .rd_valid_o (rd_valid),
    .rd_data_o  (rd_data),
    .frame_i    (frame),
    .decision_o (dec)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("Checks made %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cyc();
    @(posedge clk_sys_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    cyc();
    req.wr = 1'b0;
    cyc();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req.rd = 1'b1;
    req.addr = a;
    cyc();
    req.rd = 1'b0;
    check("rd_valid_o", {7'h0, rd_valid}, 8'h01);
    check("rd_data_o", rd_data, exp);
    cyc();
    check("rd_valid_o idle", {7'h0, rd_valid}, 8'h00);
  endtask

  initial begin
    #20000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    rst_i = 1'b1;
    req = '0;
    frame = '0;
    error_cnt = 0;
    total_checks = 0;
    rows[0]  = '{2'h0,2'h1,8'h00,8'h00,3'h4,2'h0,1'h1,1'h0,1'h0,2'h1,2'h0,1'h0,1'h0,4'h0};
    rows[1]  = '{2'h0,2'h0,8'h20,8'h00,3'h3,2'h3,1'h1,1'h1,1'h0,2'h3,2'h1,1'h1,1'h1,4'h0};
    rows[2]  = '{2'h2,2'h2,8'h21,8'h00,3'h4,2'h0,1'h1,1'h1,1'h0,2'h2,2'h1,1'h1,1'h1,4'h0};
    rows[3]  = '{2'h2,2'h2,8'h00,8'h05,3'h1,2'h1,1'h1,1'h0,1'h1,2'h1,2'h0,1'h0,1'h0,4'h0};
    rows[4]  = '{2'h3,2'h0,8'h00,8'h20,3'h4,2'h3,1'h1,1'h0,1'h1,2'h0,2'h0,1'h1,1'h1,4'h0};
    rows[5]  = '{2'h3,2'h0,8'h00,8'h3f,3'h0,2'h1,1'h1,1'h0,1'h1,2'h1,2'h1,1'h1,1'h0,4'hf};
    rows[6]  = '{2'h3,2'h0,8'h05,8'h00,3'h5,2'h2,1'h0,1'h1,1'h0,2'h2,2'h2,1'h0,1'h0,4'h0};
    rows[7]  = '{2'h2,2'h0,8'h23,8'h00,3'h0,2'h0,1'h0,1'h1,1'h0,2'h0,2'h0,1'h1,1'h0,4'h1};
    rows[8]  = '{2'h2,2'h0,8'h24,8'h00,3'h6,2'h1,1'h1,1'h1,1'h0,2'h1,2'h0,1'h1,1'h0,4'h2};
    rows[9]  = '{2'h2,2'h0,8'h27,8'h00,3'h7,2'h3,1'h0,1'h1,1'h0,2'h3,2'h3,1'h1,1'h0,4'h3};
    rows[10] = '{2'h2,2'h0,8'h3e,8'h00,3'h2,2'h2,1'h1,1'h1,1'h0,2'h2,2'h1,1'h1,1'h0,4'hf};
    rows[11] = '{2'h2,2'h0,8'h22,8'h24,3'h0,2'h0,1'h0,1'h1,1'h1,2'h0,2'h0,1'h1,1'h0,4'h1};
    rows[12] = '{2'h0,2'h2,8'h23,8'h23,3'h4,2'h0,1'h1,1'h0,1'h0,2'h2,2'h0,1'h0,1'h0,4'h0};
    rows[13] = '{2'h3,2'h0,8'h00,8'h29,3'h2,2'h2,1'h1,1'h0,1'h1,2'h2,2'h1,1'h1,1'h0,4'h4};
    repeat (8) @(posedge clk_sys_i);
    #1;
    check("decision_o reset", {3'h0, dec.valid, dec.ports}, 8'h00);
    rst_i = 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(addrs[i], dflt[i]);
    end
    for (int i = 0; i < 5; i++) begin
      wr(addrs[i], 8'hff);
      rd(addrs[i], full[i]);
    end
    for (int r = 0; r < 14; r++) begin
      wr(UQM_ADDR_SPLIT, {rows[r].sp, 6'h00});
      wr(UQM_ADDR_TAG_HI, {6'h00, rows[r].t4});
      wr(UQM_ADDR_UCAST, rows[r].uc);
      wr(UQM_ADDR_MCAST, rows[r].mc);
      frame = '{1'b1, rows[r].tag, rows[r].po, rows[r].tq, rows[r].u, rows[r].m};
      cyc();
      frame.valid = 1'b0;
      check("decision_o.valid", {7'h0, dec.valid}, 8'h01);
      check("decision_o.prio", {6'h0, dec.prio}, {6'h0, rows[r].prio});
      check("decision_o.queue", {6'h0, dec.queue}, {6'h0, rows[r].q});
      check("decision_o.apply", {7'h0, dec.apply}, {7'h0, rows[r].ap});
      check("decision_o.drop", {7'h0, dec.drop}, {7'h0, rows[r].dr});
      check("decision_o.ports", {4'h0, dec.ports}, {4'h0, rows[r].pt});
      cyc();
      check("decision_o idle", {3'h0, dec.apply, dec.ports}, 8'h00);
    end
    req = '{1'b1, 1'b1, UQM_ADDR_UCAST, 8'h2a};
    cyc();
    req = '0;
    check("rd_data_o wr+rd", rd_data, 8'h00);
    cyc();
    rd(UQM_ADDR_UCAST, 8'h2a);
    frame = '{1'b1, 3'h4, 2'h0, 1'b1, 1'b1, 1'b0};
    cyc();
    frame = '{1'b1, 3'h1, 2'h2, 1'b1, 1'b0, 1'b1};
    check("decision_o.ports first", {4'h0, dec.ports}, 8'h05);
    cyc();
    rst_i = 1'b1;
    frame = '{1'b1, 3'h0, 2'h3, 1'b1, 1'b1, 1'b0};
    check("decision_o.ports second", {4'h0, dec.ports}, 8'h04);
    check("decision_o.queue second", {6'h0, dec.queue}, 8'h01);
    cyc();
    rst_i = 1'b0;
    frame = '0;
    check("decision_o in reset", {3'h0, dec.valid, dec.ports}, 8'h00);
    for (int i = 0; i < 5; i++) begin
      rd(addrs[i], dflt[i]);
    end
    print_verdict();
  end
endmodule // testbench
